// ---- design/ccc_top.sv ----
// Calendar counter control: bus registers, sub-second count, hold handshake,
// period and alarm events, 1 Hz and 32 kHz pin outputs.
// Assumes the seconds-and-up calendar chain and alarm value registers sit
// outside and exchange steps, carries and counts with this block.
// Behaviour
// - Gate low holds block in reset, ignores writes, reads defaults.
// - Gate low also resets counting, flags and pins; sub clock sampling keeps running.
// - Count run bit stops counting at 0, starts at 1.
// - Second tick pin drives 1 Hz when enabled, disabled otherwise.
// - Clock out pin drives the 32 kHz sub clock when enabled.
// - Hour format 0 selects 12-hour with AM/PM, 1 selects 24-hour.
// - 12-hour BCD hours: AM 12,01-11; PM 32,21-31.
// - Period select picks none, 0.5 s, 1 s, minute, hour, day, month.
// - Alarm match enable makes alarm comparison effective.
// - Alarm interrupt enable lets a match raise the shared interrupt.
// - Alarm flag updates only when enabled, sets one sub clock after match.
// - Period flag sets whenever a period event happens.
// - Writing 0 clears either flag; writing 1 does nothing.
// - Hold stops seconds and up; sub-second counter keeps running.
// - Hold acknowledge reads 0 while running, 1 once hold in effect.
// - Hold acknowledge rises within one sub clock of the request.
// - Overflow during hold steps seconds once after release; seconds write cancels.
// - Period and alarm share one interrupt; flags tell the cause.
`timescale 1ns/1ps
module ccc_top (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Register bus
  input  wire logic [ccc_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic                   bus_wr,
  input  wire logic                   bus_rd,
  input  wire logic [ccc_pkg::DATA_W-1:0] bus_wdata,
  output logic      [ccc_pkg::DATA_W-1:0] bus_rdata,
  // Sub clock in
  input  wire logic                   subclk,
  // Calendar chain
  input  wire logic                   sec_write,
  input  wire logic                   carry_minute,
  input  wire logic                   carry_hour,
  input  wire logic                   carry_day,
  input  wire logic                   carry_month,
  input  wire logic [7:0]             cur_minute,
  input  wire logic [7:0]             cur_hour,
  input  wire logic [7:0]             cur_week,
  input  wire logic [7:0]             alarm_minute_value,
  input  wire logic [7:0]             alarm_hour_value,
  input  wire logic [7:0]             alarm_week_value,
  output logic                        sec_step,
  output logic                        counters_held,
  output logic                        hour_format_sel,
  output logic      [7:0]             hour_step_value,
  // Pins and interrupt
  output logic                        second_tick_pin,
  output logic                        second_tick_pin_oe,
  output logic                        subclk_out_pin,
  output logic                        subclk_out_pin_oe,
  output logic                        counter_irq
);
  import ccc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [DATA_W-1:0]   per_q, per_d;
  logic [DATA_W-1:0]   ctl0_q, ctl0_d;
  logic                match_en_q, match_en_d;
  logic                alarm_irq_en_q, alarm_irq_en_d;
  logic                alarm_hit_q, alarm_hit_d;
  logic                period_hit_q, period_hit_d;
  logic                hold_req_q, hold_req_d;
  ccc_hold_t           hold_q, hold_d;
  logic [SUBSEC_W-1:0] subsec_q, subsec_d;
  logic                pending_q, pending_d;
  logic                step_q, step_d;
  logic                match_d1_q, match_d1_d;
  logic                match_d2_q, match_d2_d;
  logic                irq_q, irq_d;
  logic                tick_pin_q, tick_pin_d;
  logic                clk_pin_q, clk_pin_d;
  logic [7:0]          hstep_q, hstep_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic                blk_rst, gate;
  logic                sub_level, sub_tick;
  logic                wr0, wr1, alarm_match, half_ev, period_ev, alarm_ev;
  logic [PERIOD_SEL_W-1:0] psel;
  logic [DATA_W-1:0]   ctl1_view;

  // Sub clock sampled into mclk; never gated by the bus clock gate
  ccc_sync_rise #(.WIDTH(1)) u_sub_sync (
    .clk   (mclk),
    .rst   (rst),
    .din   (subclk),
    .level (sub_level),
    .rise  (sub_tick)
  );

  // ****************************************************************
  // Helper functions for BCD hour stepping
  // ****************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    return r;
  endfunction

  function automatic logic [7:0] hour_next(input logic [7:0] v, input logic fmt24);
    logic [7:0] r;
    r = bcd_inc(v);
    if (fmt24) begin
      if (v == HOUR_H23) r = HOUR_ZERO;
    end else begin
      if (v == HOUR_AM12) r = HOUR_AM1;
      else if (v == HOUR_AM11) r = HOUR_PM12;
      else if (v == HOUR_PM12) r = HOUR_PM1;
      else if (v == HOUR_PM11) r = HOUR_AM12;
    end
    return r;
  endfunction

  // ****************************************************************
  // Decode and field views
  // ****************************************************************
  // Block reset while the gate is low
  assign gate    = per_q[BUS_CLOCK_GATE_BIT];
  assign blk_rst = rst | ~gate;
  assign wr0     = bus_wr & gate & (bus_addr == COUNTER_CONTROL_ZERO_ADDR);
  assign wr1     = bus_wr & gate & (bus_addr == COUNTER_CONTROL_ONE_ADDR);
  assign psel    = ctl0_q[PERIOD_SEL_LSB +: PERIOD_SEL_W];
  assign ctl1_view = {match_en_q, alarm_irq_en_q, 1'b0, alarm_hit_q, period_hit_q,
                      1'b0, (hold_q == CCC_HOLD_HELD), hold_req_q};

  // Alarm compare of week, hour and minute
  assign alarm_match = match_en_q & (cur_week == alarm_week_value) &
                       (cur_hour == alarm_hour_value) &
                       (cur_minute == alarm_minute_value);
  assign half_ev  = sub_tick & ctl0_q[COUNT_RUN_BIT] & (subsec_q == SUBSEC_HALF);
  assign alarm_ev = sub_tick & match_d1_q & ~match_d2_q;

  // Period event select, qualified by the seconds step; 0.5 s also fires at the half-second point
  always_comb begin
    case (psel)
      PER_NONE:   period_ev = 1'b0;
      PER_HALF_S: period_ev = step_q | half_ev;
      PER_SECOND: period_ev = step_q;
      PER_MINUTE: period_ev = step_q & carry_minute;
      PER_HOUR:   period_ev = step_q & carry_hour;
      PER_DAY:    period_ev = step_q & carry_day;
      default:    period_ev = step_q & carry_month;
    endcase
  end

  // ****************************************************************
  // Peripheral enable register (not held by the gate)
  // ****************************************************************
  always_comb begin
    per_d = per_q;
    if (bus_wr && bus_addr == PERIPHERAL_ENABLE_ADDR) begin
      per_d = bus_wdata;
      per_d[PER_RESERVED_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      per_q <= PERIPHERAL_ENABLE_RST;
    end else begin
      per_q <= per_d;
    end
  end

  // ****************************************************************
  // Control registers and flags
  // ****************************************************************
  // Writes, flag clear by zero, hardware set wins
  always_comb begin
    ctl0_d         = ctl0_q;
    match_en_d     = match_en_q;
    alarm_irq_en_d = alarm_irq_en_q;
    hold_req_d     = hold_req_q;
    alarm_hit_d    = alarm_hit_q;
    period_hit_d   = period_hit_q;
    if (wr0) begin
      ctl0_d = bus_wdata;
      ctl0_d[6] = 1'b0;
    end
    if (wr1) begin
      match_en_d     = bus_wdata[ALARM_MATCH_EN_BIT];
      alarm_irq_en_d = bus_wdata[ALARM_IRQ_EN_BIT];
      hold_req_d     = bus_wdata[HOLD_REQUEST_BIT];
      if (!bus_wdata[ALARM_HIT_BIT]) alarm_hit_d = 1'b0;
      if (!bus_wdata[PERIOD_HIT_BIT]) period_hit_d = 1'b0;
    end
    if (alarm_ev) alarm_hit_d = 1'b1;
    if (period_ev) period_hit_d = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      ctl0_q         <= COUNTER_CONTROL_ZERO_RST;
      match_en_q     <= COUNTER_CONTROL_ONE_RST[ALARM_MATCH_EN_BIT];
      alarm_irq_en_q <= COUNTER_CONTROL_ONE_RST[ALARM_IRQ_EN_BIT];
      hold_req_q     <= COUNTER_CONTROL_ONE_RST[HOLD_REQUEST_BIT];
      alarm_hit_q    <= COUNTER_CONTROL_ONE_RST[ALARM_HIT_BIT];
      period_hit_q   <= COUNTER_CONTROL_ONE_RST[PERIOD_HIT_BIT];
    end else begin
      ctl0_q         <= ctl0_d;
      match_en_q     <= match_en_d;
      alarm_irq_en_q <= alarm_irq_en_d;
      hold_req_q     <= hold_req_d;
      alarm_hit_q    <= alarm_hit_d;
      period_hit_q   <= period_hit_d;
    end
  end

  // ****************************************************************
  // Hold handshake
  // ****************************************************************
  // Acknowledge on the next sub clock edge after the request
  always_comb begin
    case (hold_q)
      CCC_HOLD_RUN:  hold_d = hold_req_q ? CCC_HOLD_WAIT : CCC_HOLD_RUN;
      CCC_HOLD_WAIT: hold_d = !hold_req_q ? CCC_HOLD_RUN :
                              (sub_tick ? CCC_HOLD_HELD : CCC_HOLD_WAIT);
      CCC_HOLD_HELD: hold_d = hold_req_q ? CCC_HOLD_HELD : CCC_HOLD_RUN;
      default:       hold_d = CCC_HOLD_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      hold_q <= CCC_HOLD_RUN;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ****************************************************************
  // Sub-second counter, seconds step and alarm pipeline
  // ****************************************************************
  always_comb begin
    subsec_d   = subsec_q;
    pending_d  = pending_q;
    step_d     = 1'b0;
    match_d1_d = match_d1_q;
    match_d2_d = match_d2_q;
    if (sub_tick) begin
      match_d1_d = alarm_match;
      match_d2_d = match_d1_q;
    end
    if (sub_tick && ctl0_q[COUNT_RUN_BIT]) begin
      subsec_d = (subsec_q == SUBSEC_LAST) ? SUBSEC_RST : subsec_q + 15'h0001;
      if (hold_req_q) begin
        if (subsec_q == SUBSEC_LAST) pending_d = 1'b1;
      end else if ((subsec_q == SUBSEC_LAST) || pending_q) begin
        step_d    = 1'b1;
        pending_d = 1'b0;
      end
    end
    if (sec_write) begin
      subsec_d  = SUBSEC_RST;
      pending_d = 1'b0;
      step_d    = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      subsec_q   <= SUBSEC_RST;
      pending_q  <= 1'b0;
      step_q     <= 1'b0;
      match_d1_q <= 1'b0;
      match_d2_q <= 1'b0;
    end else begin
      subsec_q   <= subsec_d;
      pending_q  <= pending_d;
      step_q     <= step_d;
      match_d1_q <= match_d1_d;
      match_d2_q <= match_d2_d;
    end
  end

  // ****************************************************************
  // Outputs: interrupt, pins, hour step, read data
  // ****************************************************************
  always_comb begin
    irq_d      = period_ev | (alarm_ev & alarm_irq_en_q);
    tick_pin_d = ctl0_q[SECOND_TICK_EN_BIT] & ~subsec_q[SUBSEC_W-1];
    clk_pin_d  = ctl0_q[SUBCLK_OUT_EN_BIT] & sub_level;
    hstep_d    = hour_next(cur_hour, ctl0_q[HOUR_FORMAT_BIT]);
    rdata_d    = rdata_q;
    if (bus_rd) begin
      if (bus_addr == PERIPHERAL_ENABLE_ADDR) rdata_d = per_q;
      else if (bus_addr == COUNTER_CONTROL_ZERO_ADDR) rdata_d = ctl0_q;
      else if (bus_addr == COUNTER_CONTROL_ONE_ADDR) rdata_d = ctl1_view;
      else rdata_d = UNMAPPED_READ;
    end
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      irq_q      <= 1'b0;
      tick_pin_q <= 1'b0;
      clk_pin_q  <= 1'b0;
      hstep_q    <= HOUR_RST;
    end else begin
      irq_q      <= irq_d;
      tick_pin_q <= tick_pin_d;
      clk_pin_q  <= clk_pin_d;
      hstep_q    <= hstep_d;
    end
  end

  // Read data keeps working while the gate is low
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata          = rdata_q;
  assign sec_step           = step_q;
  assign counters_held      = hold_req_q;
  assign hour_format_sel    = ctl0_q[HOUR_FORMAT_BIT];
  assign hour_step_value    = hstep_q;
  assign second_tick_pin    = tick_pin_q;
  assign second_tick_pin_oe = ctl0_q[SECOND_TICK_EN_BIT];
  assign subclk_out_pin     = clk_pin_q;
  assign subclk_out_pin_oe  = ctl0_q[SUBCLK_OUT_EN_BIT];
  assign counter_irq        = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  gate_low_reset_a: assert property (@(posedge mclk) disable iff (rst)
    !gate |=> (ctl0_q == COUNTER_CONTROL_ZERO_RST) && !hold_req_q)
    else $error("control not held at default with gate low");
  run_stop_a: assert property (@(posedge mclk) disable iff (blk_rst)
    !ctl0_q[COUNT_RUN_BIT] && !sec_write |=> $stable(subsec_q))
    else $error("sub-second count moved while stopped");
  tick_pin_a: assert property (@(posedge mclk) disable iff (blk_rst)
    !ctl0_q[SECOND_TICK_EN_BIT] |=> !second_tick_pin)
    else $error("second tick pin active while disabled");
  hold_no_step_a: assert property (@(posedge mclk) disable iff (blk_rst)
    hold_req_q && $past(hold_req_q) |-> !step_q)
    else $error("seconds stepped during hold");
  ack_low_a: assert property (@(posedge mclk) disable iff (blk_rst)
    !hold_req_q |=> !ctl1_view[HOLD_ACK_BIT])
    else $error("hold ack high without request");
  ack_rise_a: assert property (@(posedge mclk) disable iff (blk_rst)
    hold_req_q && sub_tick && hold_q == CCC_HOLD_WAIT |=> hold_q == CCC_HOLD_HELD)
    else $error("hold ack missed first sub clock edge");
  pend_step_a: assert property (@(posedge mclk) disable iff (blk_rst)
    pending_q && !hold_req_q && sub_tick && ctl0_q[COUNT_RUN_BIT] && !sec_write
    |=> step_q && !pending_q)
    else $error("pending seconds step not taken after release");
  flag_set_a: assert property (@(posedge mclk) disable iff (blk_rst)
    period_ev |=> period_hit_q ##0 counter_irq)
    else $error("period event lost flag or interrupt");
  alarm_gate_a: assert property (@(posedge mclk) disable iff (blk_rst)
    alarm_ev && !alarm_irq_en_q && !period_ev |=> !counter_irq)
    else $error("alarm raised interrupt while disabled");
  flag_one_a: assert property (@(posedge mclk) disable iff (blk_rst)
    wr1 && bus_wdata[ALARM_HIT_BIT] && !alarm_hit_q && !alarm_ev |=> !alarm_hit_q)
    else $error("writing one set the alarm flag");

endmodule

// ---- common/ccc_pkg.sv ----
// Shared constants for the calendar counter control block.
// Assumes one CPU clock and byte registers on a 20-bit address bus.
package ccc_pkg;

  // ****************************************************************
  // Bus shape
  // ****************************************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PERIPHERAL_ENABLE_ADDR    = 20'hf00f0;
  localparam logic [ADDR_W-1:0] COUNTER_CONTROL_ZERO_ADDR = 20'hfff9d;
  localparam logic [ADDR_W-1:0] COUNTER_CONTROL_ONE_ADDR  = 20'hfff9e;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] PERIPHERAL_ENABLE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] COUNTER_CONTROL_ZERO_RST = 8'h00;
  localparam logic [DATA_W-1:0] COUNTER_CONTROL_ONE_RST  = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ            = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BUS_CLOCK_GATE_BIT  = 7;
  localparam int PER_RESERVED_BIT    = 1;
  localparam int COUNT_RUN_BIT       = 7;
  localparam int SECOND_TICK_EN_BIT  = 5;
  localparam int SUBCLK_OUT_EN_BIT   = 4;
  localparam int HOUR_FORMAT_BIT     = 3;
  localparam int PERIOD_SEL_LSB      = 0;
  localparam int PERIOD_SEL_W        = 3;
  localparam int ALARM_MATCH_EN_BIT  = 7;
  localparam int ALARM_IRQ_EN_BIT    = 6;
  localparam int ALARM_HIT_BIT       = 4;
  localparam int PERIOD_HIT_BIT      = 3;
  localparam int HOLD_ACK_BIT        = 1;
  localparam int HOLD_REQUEST_BIT    = 0;

  // ****************************************************************
  // Period select codes
  // ****************************************************************
  localparam logic [PERIOD_SEL_W-1:0] PER_NONE   = 3'h0;
  localparam logic [PERIOD_SEL_W-1:0] PER_HALF_S = 3'h1;
  localparam logic [PERIOD_SEL_W-1:0] PER_SECOND = 3'h2;
  localparam logic [PERIOD_SEL_W-1:0] PER_MINUTE = 3'h3;
  localparam logic [PERIOD_SEL_W-1:0] PER_HOUR   = 3'h4;
  localparam logic [PERIOD_SEL_W-1:0] PER_DAY    = 3'h5;

  // ****************************************************************
  // Sub-second counter and hour encoding
  // ****************************************************************
  localparam int                 SUBSEC_W    = 15;
  localparam logic [SUBSEC_W-1:0] SUBSEC_RST  = 15'h0000;
  localparam logic [SUBSEC_W-1:0] SUBSEC_LAST = 15'h7fff;
  localparam logic [SUBSEC_W-1:0] SUBSEC_HALF = 15'h3fff;
  localparam logic [7:0] HOUR_RST   = 8'h12;
  localparam logic [7:0] HOUR_ZERO  = 8'h00;
  localparam logic [7:0] HOUR_AM1   = 8'h01;
  localparam logic [7:0] HOUR_AM11  = 8'h11;
  localparam logic [7:0] HOUR_AM12  = 8'h12;
  localparam logic [7:0] HOUR_PM1   = 8'h21;
  localparam logic [7:0] HOUR_PM11  = 8'h31;
  localparam logic [7:0] HOUR_PM12  = 8'h32;
  localparam logic [7:0] HOUR_H23   = 8'h23;

  // ****************************************************************
  // Clock and hold handshake
  // ****************************************************************
  localparam int MCLK_PERIOD_NS = 50;

  typedef enum logic [2:0] {
    CCC_HOLD_RUN  = 3'b001,
    CCC_HOLD_WAIT = 3'b010,
    CCC_HOLD_HELD = 3'b100
  } ccc_hold_t;

endpackage

// ---- design/ccc_sync_rise.sv ----
// Two-stage synchroniser with rising-edge detect, WIDTH lanes.
// Assumes din may change at any time relative to clk.
`timescale 1ns/1ps
module ccc_sync_rise #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw input and results
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] stab_d;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  // Next values: first stage only feeds the second
  always_comb begin
    meta_d = din;
    stab_d = meta_q;
    prev_d = stab_q;
  end

  // Register stages
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      stab_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      prev_q <= prev_d;
    end
  end

  assign level = stab_q;
  assign rise  = stab_q & ~prev_q;

endmodule

// ---- testbench/ccc_sub_model.sv ----
// Far side stand-in: free-running sub clock and the outer calendar counts.
// Assumes the bench sets the calendar value; the carries never fire here.
`timescale 1ns/1ps
module ccc_sub_model (
  // Clock
  input  wire logic       mclk,
  // Calendar value from the bench
  input  wire logic [7:0] cal_set,
  // Towards the block
  output logic            subclk,
  output logic            carry_out,
  output logic [7:0]      cur_val
);
  // *****************************************************
  // Sub clock, runs whatever the gate or reset does
  // *****************************************************
  logic sub_q = 1'b0;
  // Toggles every cycle, a fast stand-in so a whole second fits in the run
  always @(posedge mclk) begin
    sub_q <= ~sub_q;
  end
  assign subclk = sub_q;
  // Calendar holds its value, so no carry ever arrives
  assign carry_out = 1'b0;
  assign cur_val   = cal_set;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the calendar counter control block.
// Assumes the strobe bus of the block and a fast sub clock from the model.
`timescale 1ns/1ps
module testbench;
  import ccc_pkg::*;
  // *****************************************************
  // Signals
  // *****************************************************
  logic mclk = 0, rst = 1, bus_wr = 0, bus_rd = 0, sec_write = 0, rd_t = 0;
  logic [19:0] bus_addr = '0;
  logic [7:0] bus_wdata = '0, bus_rdata, cal, alarm_val = '0, hsv;
  logic subclk, cy, sec_step, held, fmt, tick, tick_oe, sco, sco_oe, irq;
  logic [7:0] d;
  logic [31:0] seed = 32'h80285dbe;
  logic [7:0] exp_q[$];
  int error_cnt = 0, check_count = 0, irq_n = 0, step_n = 0, h;
  always #25 mclk = ~mclk;
  ccc_sub_model i_sub (.mclk(mclk), .cal_set(alarm_val), .subclk(subclk),
    .carry_out(cy), .cur_val(cal));
  ccc_top i_dut (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .subclk(subclk),
    .sec_write(sec_write), .carry_minute(cy), .carry_hour(cy), .carry_day(cy),
    .carry_month(cy), .cur_minute(cal), .cur_hour(cal), .cur_week(cal),
    .alarm_minute_value(alarm_val), .alarm_hour_value(alarm_val),
    .alarm_week_value(alarm_val), .sec_step(sec_step), .counters_held(held),
    .hour_format_sel(fmt), .hour_step_value(hsv), .second_tick_pin(tick),
    .second_tick_pin_oe(tick_oe), .subclk_out_pin(sco),
    .subclk_out_pin_oe(sco_oe), .counter_irq(irq));
  // *****************************************************
  // Helpers
  // *****************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic bad(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) bad("pin level");
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    @(negedge mclk);
    bus_addr = a; bus_wdata = v; bus_wr = 1;
    @(negedge mclk);
    bus_wr = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(negedge mclk);
    bus_addr = a; bus_rd = 1; exp_q.push_back(e);
    @(negedge mclk);
    bus_rd = 0;
  endtask
  // Count high cycles of the clock-out pin over sixteen cycles
  task automatic watch_sco();
    h = 0;
    repeat (16) begin
      @(negedge mclk);
      h += (sco === 1'b1);
    end
  endtask
  // *****************************************************
  // Read-data watcher and interrupt counter
  // *****************************************************
  always @(posedge mclk) rd_t <= bus_rd;
  always @(posedge mclk) if (irq === 1'b1) irq_n++;
  always @(posedge mclk) if (sec_step === 1'b1) step_n++;
  always @(negedge mclk) begin
    if (rd_t) begin
      check_count++;
      if (bus_rdata !== exp_q[0]) bad("read data");
      void'(exp_q.pop_front());
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #4000000;
    error_cnt++;
    close_out();
  end
  // *****************************************************
  // Main sequence
  // *****************************************************
  initial begin
    repeat (20) @(negedge mclk);
    rst = 0;
    rd(PERIPHERAL_ENABLE_ADDR, 8'h00);
    rd(20'hfff9f, UNMAPPED_READ);
    wr(COUNTER_CONTROL_ZERO_ADDR, 8'hff);
    rd(COUNTER_CONTROL_ZERO_ADDR, 8'h00);
    wr(PERIPHERAL_ENABLE_ADDR, 8'h82);
    rd(PERIPHERAL_ENABLE_ADDR, 8'h80);
    // Every period code, random enables and format, stopped and held
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h01);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = (seed[7:0] & 8'h38) | 8'(i);
      wr(COUNTER_CONTROL_ZERO_ADDR, d);
      rd(COUNTER_CONTROL_ZERO_ADDR, d);
      chk(fmt, d[3]);
      chk(tick_oe, d[5]);
      chk(sco_oe, d[4]);
    end
    wr(COUNTER_CONTROL_ZERO_ADDR, 8'h00);
    watch_sco();
    chk(h == 0, 1'b1);
    chk(tick, 1'b0);
    wr(COUNTER_CONTROL_ZERO_ADDR, 8'h30);
    wr(COUNTER_CONTROL_ZERO_ADDR, 8'hb0);
    rd(COUNTER_CONTROL_ZERO_ADDR, 8'hb0);
    watch_sco();
    chk(h > 3 && h < 13, 1'b1);
    chk(tick, 1'b1);
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h18);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'h00);
    // Hold handshake
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h01);
    chk(held, 1'b1);
    repeat (16) @(negedge mclk);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'h03);
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h00);
    repeat (2) @(negedge mclk);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'h00);
    // Next hour after AM11 in 12-hour format
    alarm_val = HOUR_AM11;
    repeat (2) @(negedge mclk);
    chk(hsv == HOUR_PM12, 1'b1);
    // Alarm match with interrupt, then without
    seed = lfsr(seed);
    alarm_val = seed[7:0];
    irq_n = 0;
    wr(COUNTER_CONTROL_ONE_ADDR, 8'hc0);
    repeat (24) @(negedge mclk);
    chk(irq_n == 1, 1'b1);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'hd0);
    wr(COUNTER_CONTROL_ONE_ADDR, 8'hc0);
    repeat (24) @(negedge mclk);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'hc0);
    irq_n = 0;
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h00);
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h80);
    repeat (24) @(negedge mclk);
    chk(irq_n == 0, 1'b1);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'h90);
    // Half-second and seconds events from a cleared sub-second count
    wr(COUNTER_CONTROL_ZERO_ADDR, 8'hb1);
    wr(COUNTER_CONTROL_ONE_ADDR, 8'h90);
    irq_n = 0;
    @(negedge mclk) sec_write = 1;
    @(negedge mclk) sec_write = 0;
    repeat (66000) @(negedge mclk);
    chk(irq_n == 2, 1'b1);
    chk(step_n == 1, 1'b1);
    rd(COUNTER_CONTROL_ONE_ADDR, 8'h98);
    // Gate off resets the block
    wr(PERIPHERAL_ENABLE_ADDR, 8'h00);
    rd(COUNTER_CONTROL_ZERO_ADDR, 8'h00);
    chk(sco_oe, 1'b0);
    repeat (3) @(negedge mclk);
    close_out();
  end
endmodule
